// File: bkreg_bank.sv
// Control and configuration register bank of the first buck regulator.
// Assumes a same-clock register port from the control interface and one system power state input.
// Contract
// - Six-bit standby voltage code, used in standby
// - Six-bit sleep voltage code, used in sleep
// - Fuse fields load at reset, stay writable
// - Control bit 0 enables run state
// - Run enable zero, then fuse loaded
// - Bit 1 standby enable, fuse default run
// - Bit 2 enables regulator in sleep
// - Sleep enable also set asynchronously
// - Bit 3 selects low power standby/sleep
// - Bit 4 slew select, fuse override ignores
// - Bit 5 forces conduction on falling scaling
// - Bit 6 forces fixed pulse width mode
// - Bit 7 low connects discharge when off
// - Two-bit current limit, default zero
// - Bit 4 selects on or off time
module bkreg_bank (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  input wire logic i_fuse_load,
  input wire logic [5:0] i_fuse_standby_vcode,
  input wire logic [5:0] i_fuse_sleep_vcode,
  input wire logic i_fuse_run_enable,
  input wire logic i_fuse_slew_select,
  input wire logic i_fuse_discharge_disable_n,
  input wire logic [1:0] i_fuse_current_limit,
  input wire logic i_fuse_buck1_scaling_select,
  input wire logic i_sleep_enable_set,
  input wire logic [1:0] i_power_state,
  input wire logic [5:0] i_buck1_run_voltage_code,
  output logic [5:0] o_target_voltage_code,
  output logic o_regulator_enable,
  output logic o_low_power,
  output logic o_scaling_slow,
  output logic o_forced_pwm_on_falling,
  output logic o_forced_pwm,
  output logic o_discharge_connect,
  output logic [1:0] o_current_limit,
  output logic o_timing_method_select
);
  bkreg_fuse_if fuse ();

  bkreg_fuse_loader u_loader (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(i_fuse_load),
    .i_standby_vcode(i_fuse_standby_vcode),
    .i_sleep_vcode(i_fuse_sleep_vcode),
    .i_run_enable(i_fuse_run_enable),
    .i_slew_select(i_fuse_slew_select),
    .i_discharge_disable_n(i_fuse_discharge_disable_n),
    .i_current_limit(i_fuse_current_limit),
    .fuse(fuse)
  );

  // Sleep enable set comes from outside the clock domain
  logic sset_m_q, sset_s_q, sset_m_d, sset_s_d;
  always_comb begin
    sset_m_d = i_sleep_enable_set;
    sset_s_d = sset_m_q;
  end

  // Only the second stage is read; the first may still be settling
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sset_m_q <= 1'b0;
      sset_s_q <= 1'b0;
    end else begin
      sset_m_q <= sset_m_d;
      sset_s_q <= sset_s_d;
    end
  end

  logic [5:0] stby_q, stby_d;
  logic [5:0] slp_q, slp_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [1:0] ilim_q, ilim_d;
  logic tmode_q, tmode_d;
  logic [7:0] rdata_q, rdata_d;
  logic rdv_q, rdv_d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  logic wr_stby, wr_slp, wr_ctrl, wr_lim;
  assign wr_stby = i_wr_en && hit(i_addr, bkreg_pkg::ADDR_STANDBY_VOLTAGE);
  assign wr_slp = i_wr_en && hit(i_addr, bkreg_pkg::ADDR_SLEEP_VOLTAGE);
  assign wr_ctrl = i_wr_en && hit(i_addr, bkreg_pkg::ADDR_CONTROL);
  assign wr_lim = i_wr_en && hit(i_addr, bkreg_pkg::ADDR_LIMIT_CONFIG);

  // Fuse apply wins over a host write in the same cycle for the fields it loads; the set pin wins over a write of sleep enable
  always_comb begin
    stby_d = stby_q;
    slp_d = slp_q;
    ctrl_d = ctrl_q;
    ilim_d = ilim_q;
    tmode_d = tmode_q;
    if (wr_stby) begin
      stby_d = i_wdata[5:0];
    end
    if (wr_slp) begin
      slp_d = i_wdata[5:0];
    end
    if (wr_ctrl) begin
      ctrl_d = i_wdata & bkreg_pkg::CTRL_MASK;
    end
    if (wr_lim) begin
      ilim_d = i_wdata[bkreg_pkg::LIM_ILIM_LSB +: bkreg_pkg::ILIM_W];
      tmode_d = i_wdata[bkreg_pkg::LIM_TMODE];
    end
    if (fuse.apply) begin
      stby_d = fuse.standby_vcode;
      slp_d = fuse.sleep_vcode;
      ctrl_d[bkreg_pkg::CTRL_RUN_EN] = fuse.run_enable;
      ctrl_d[bkreg_pkg::CTRL_STBY_EN] = fuse.run_enable;
      ctrl_d[bkreg_pkg::CTRL_SLEW] = fuse.slew_select;
      ctrl_d[bkreg_pkg::CTRL_DISCH_N] = fuse.discharge_disable_n;
      ilim_d = fuse.current_limit;
    end
    if (sset_s_q) begin
      ctrl_d[bkreg_pkg::CTRL_SLEEP_EN] = 1'b1;
    end
  end

  always_comb begin
    rdv_d = i_rd_en;
    rdata_d = rdata_q;
    if (i_rd_en) begin
      case (i_addr)
        bkreg_pkg::ADDR_STANDBY_VOLTAGE: rdata_d = {2'h0, stby_q};
        bkreg_pkg::ADDR_SLEEP_VOLTAGE: rdata_d = {2'h0, slp_q};
        bkreg_pkg::ADDR_CONTROL: rdata_d = ctrl_q;
        bkreg_pkg::ADDR_LIMIT_CONFIG: rdata_d = {3'h0, tmode_q, 2'h0, ilim_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stby_q <= bkreg_pkg::RST_VCODE;
      slp_q <= bkreg_pkg::RST_VCODE;
      ctrl_q <= bkreg_pkg::RST_CONTROL;
      ilim_q <= bkreg_pkg::RST_ILIM;
      tmode_q <= bkreg_pkg::RST_TMODE;
    end else begin
      stby_q <= stby_d;
      slp_q <= slp_d;
      ctrl_q <= ctrl_d;
      ilim_q <= ilim_d;
      tmode_q <= tmode_d;
    end
  end

  // Read data is registered so the host port sees a clean one-cycle answer
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
      rdv_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rdv_q <= rdv_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rd_valid = rdv_q;

  // Per-state steering; an unknown state code is treated as run so the output never floats
  logic in_stby, in_slp, en_now;
  assign in_stby = (i_power_state == bkreg_pkg::PST_STANDBY);
  assign in_slp = (i_power_state == bkreg_pkg::PST_SLEEP);
  assign en_now = in_slp ? ctrl_q[bkreg_pkg::CTRL_SLEEP_EN] :
                  in_stby ? ctrl_q[bkreg_pkg::CTRL_STBY_EN] : ctrl_q[bkreg_pkg::CTRL_RUN_EN];
  assign o_regulator_enable = en_now;
  assign o_target_voltage_code = in_slp ? slp_q : in_stby ? stby_q : i_buck1_run_voltage_code;
  assign o_low_power = ctrl_q[bkreg_pkg::CTRL_LOW_POWER] & (in_stby | in_slp);
  assign o_scaling_slow = ctrl_q[bkreg_pkg::CTRL_SLEW] & ~i_fuse_buck1_scaling_select;
  assign o_forced_pwm_on_falling = ctrl_q[bkreg_pkg::CTRL_FORCED_PULSE_WIDTH_FALL];
  assign o_forced_pwm = ctrl_q[bkreg_pkg::CTRL_FORCED_PULSE_WIDTH];
  assign o_discharge_connect = ~ctrl_q[bkreg_pkg::CTRL_DISCH_N] & ~en_now;
  assign o_current_limit = ilim_q;
  assign o_timing_method_select = tmode_q;

  sequence s_fuse_req;
    i_fuse_load && !$past(i_fuse_load);
  endsequence

  sequence s_write_ctrl;
    wr_ctrl && !fuse.apply && !sset_s_q;
  endsequence

  sequence s_fuse_apply;
    s_fuse_req ##1 fuse.apply;
  endsequence

  sequence s_write_slp;
    wr_slp && !fuse.apply;
  endsequence

  sequence s_read_unmapped;
    i_rd_en && (i_addr < bkreg_pkg::ADDR_STANDBY_VOLTAGE || i_addr > bkreg_pkg::ADDR_LIMIT_CONFIG);
  endsequence

  a_fuse_run_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fuse.apply && !wr_ctrl |=> ctrl_q[bkreg_pkg::CTRL_RUN_EN] == $past(fuse.run_enable))
    else $error("run enable not loaded from fuse");
  a_fuse_stby_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fuse.apply |=> ctrl_q[bkreg_pkg::CTRL_STBY_EN] == ctrl_q[bkreg_pkg::CTRL_RUN_EN])
    else $error("standby enable differs from run after fuse load");
  a_fuse_volt_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_fuse_req ##1 fuse.apply |=> stby_q == $past(fuse.standby_vcode) && slp_q == $past(fuse.sleep_vcode))
    else $error("voltage codes not loaded from fuse");
  a_ctrl_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_write_ctrl |=> ctrl_q == $past(i_wdata))
    else $error("control write not stored");
  a_sleep_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(i_sleep_enable_set) ##1 i_sleep_enable_set |-> ##[1:2] ctrl_q[bkreg_pkg::CTRL_SLEEP_EN])
    else $error("sleep enable not set by pin");
  a_state_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    in_slp |-> o_regulator_enable == ctrl_q[bkreg_pkg::CTRL_SLEEP_EN])
    else $error("sleep enable not applied in sleep");
  a_stby_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_stby && !fuse.apply ##1 in_stby |-> o_target_voltage_code == $past(i_wdata[5:0]))
    else $error("standby code not applied");
  a_slew_override: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_fuse_buck1_scaling_select |-> !o_scaling_slow)
    else $error("slew select not ignored");
  a_discharge_conn: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_discharge_connect |-> !o_regulator_enable && !ctrl_q[bkreg_pkg::CTRL_DISCH_N])
    else $error("discharge connected while enabled or disabled by bit");
  a_unused_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rd_en && (hit(i_addr, bkreg_pkg::ADDR_LIMIT_CONFIG) || hit(i_addr, bkreg_pkg::ADDR_SLEEP_VOLTAGE))
    |=> (o_rdata & ~(bkreg_pkg::LIM_MASK | bkreg_pkg::VOLT_MASK)) == 8'h00 && o_rd_valid)
    else $error("unused bits read nonzero");
  a_lim_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_lim && !fuse.apply |=> o_current_limit == $past(i_wdata[1:0]) && o_timing_method_select == $past(i_wdata[4]))
    else $error("limit config write not applied");
  a_sleep_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_write_slp ##1 in_slp |-> o_target_voltage_code == $past(i_wdata[5:0]))
    else $error("sleep code not applied");
  a_lp_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_write_ctrl ##1 (in_stby || in_slp) |-> o_low_power == $past(i_wdata[bkreg_pkg::CTRL_LOW_POWER]))
    else $error("low power select not applied in standby or sleep");
  a_fall_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_write_ctrl |=> o_forced_pwm_on_falling == $past(i_wdata[bkreg_pkg::CTRL_FORCED_PULSE_WIDTH_FALL]))
    else $error("falling forcing bit not applied");
  a_forced_pulse_width_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_write_ctrl |=> o_forced_pwm == $past(i_wdata[bkreg_pkg::CTRL_FORCED_PULSE_WIDTH]))
    else $error("forced pulse width bit not applied");

  // Fuse fields land one edge after the load request is taken
  a_fuse_ilim: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_fuse_apply |=> o_current_limit == $past(i_fuse_current_limit, 2))
    else $error("current limit not loaded from fuse");
  a_fuse_slew: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_fuse_apply |=> ctrl_q[bkreg_pkg::CTRL_SLEW] == $past(i_fuse_slew_select, 2))
    else $error("slew select not loaded from fuse");
  a_fuse_disch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_fuse_apply |=> ctrl_q[bkreg_pkg::CTRL_DISCH_N] == $past(i_fuse_discharge_disable_n, 2))
    else $error("discharge bit not loaded from fuse");
  a_tmode_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fuse.apply && !wr_lim |=> o_timing_method_select == $past(o_timing_method_select))
    else $error("timing method changed by fuse load");
  a_sleep_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fuse.apply && !wr_ctrl && !sset_s_q
    |=> ctrl_q[bkreg_pkg::CTRL_SLEEP_EN] == $past(ctrl_q[bkreg_pkg::CTRL_SLEEP_EN]))
    else $error("sleep enable changed by fuse load");

  // Read path: registered answer, zeros in unused and unmapped places
  a_read_valid: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rd_en |=> o_rd_valid)
    else $error("read not answered");
  a_rdata_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_rd_en |=> $stable(o_rdata) && !o_rd_valid)
    else $error("read data moved without a read");
  a_stby_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rd_en && hit(i_addr, bkreg_pkg::ADDR_STANDBY_VOLTAGE) |=> o_rdata == {2'h0, $past(stby_q)})
    else $error("standby code read wrong");
  a_ctrl_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rd_en && hit(i_addr, bkreg_pkg::ADDR_CONTROL) |=> o_rdata == $past(ctrl_q))
    else $error("control register read wrong");
  a_unmapped_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_read_unmapped |=> o_rdata == 8'h00)
    else $error("unmapped read nonzero");
  a_lim_unused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rd_en && hit(i_addr, bkreg_pkg::ADDR_LIMIT_CONFIG) |=> (o_rdata & ~bkreg_pkg::LIM_MASK) == 8'h00)
    else $error("unused limit config bits read nonzero");
endmodule

// File: bkreg_fuse_if.sv
// Carries captured fuse values and the one-cycle apply strobe from loader to register bank.
// Assumes both ends share one clock.
interface bkreg_fuse_if;
  logic apply;
  logic [5:0] standby_vcode;
  logic [5:0] sleep_vcode;
  logic run_enable;
  logic slew_select;
  logic discharge_disable_n;
  logic [1:0] current_limit;
  modport loader (output apply, standby_vcode, sleep_vcode, run_enable, slew_select,
                  discharge_disable_n, current_limit);
  modport bank (input apply, standby_vcode, sleep_vcode, run_enable, slew_select,
                discharge_disable_n, current_limit);
endinterface

// File: bkreg_fuse_loader.sv
// Captures fuse values on a load request and hands them over with one apply strobe.
// Assumes the fuse controller holds its values steady and pulses the load request on this clock.
module bkreg_fuse_loader (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [5:0] i_standby_vcode,
  input wire logic [5:0] i_sleep_vcode,
  input wire logic i_run_enable,
  input wire logic i_slew_select,
  input wire logic i_discharge_disable_n,
  input wire logic [1:0] i_current_limit,
  bkreg_fuse_if.loader fuse
);
  bkreg_pkg::bkreg_ld_state_t st_q, st_d;
  // Standby code, sleep code, run enable, slew, discharge, current limit
  logic [16:0] cap_q, cap_d;

  always_comb begin
    st_d = st_q;
    cap_d = cap_q;
    case (st_q)
      bkreg_pkg::LD_IDLE: begin
        if (i_load) begin
          st_d = bkreg_pkg::LD_APPLY;
          cap_d = {i_standby_vcode, i_sleep_vcode, i_run_enable, i_slew_select, i_discharge_disable_n,
                   i_current_limit};
        end
      end
      bkreg_pkg::LD_APPLY: st_d = bkreg_pkg::LD_DONE;
      // A held request loads once; a new one needs the request to drop first
      bkreg_pkg::LD_DONE: begin
        if (!i_load) begin
          st_d = bkreg_pkg::LD_IDLE;
        end
      end
      default: st_d = bkreg_pkg::LD_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= bkreg_pkg::LD_IDLE;
      cap_q <= 17'h00000;
    end else begin
      st_q <= st_d;
      cap_q <= cap_d;
    end
  end

  assign fuse.apply = (st_q == bkreg_pkg::LD_APPLY);
  assign fuse.standby_vcode = cap_q[16:11];
  assign fuse.sleep_vcode = cap_q[10:5];
  assign fuse.run_enable = cap_q[4];
  assign fuse.slew_select = cap_q[3];
  assign fuse.discharge_disable_n = cap_q[2];
  assign fuse.current_limit = cap_q[1:0];
endmodule

// File: bkreg_host_model.sv
// Host model that reaches the register bank through its byte-wide register port.
// Assumes the bank takes requests on the rising edge and answers reads one cycle later.
module bkreg_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rd_valid,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    // Released lines show the inverse so stale values cannot pass by luck
    o_addr = ~a;
    o_wdata = ~d;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    d = i_rdata;
    v = i_rd_valid;
    o_rd_en = 1'b0;
    o_addr = ~a;
  endtask
endmodule

// File: bkreg_pkg.sv
// Constants for the first buck regulator control register bank.
// Assumes an 8-bit register port driven by the control interface logic on the same clock.
package bkreg_pkg;
  localparam logic [7:0] ADDR_STANDBY_VOLTAGE = 8'h33;
  localparam logic [7:0] ADDR_SLEEP_VOLTAGE = 8'h34;
  localparam logic [7:0] ADDR_CONTROL = 8'h35;
  localparam logic [7:0] ADDR_LIMIT_CONFIG = 8'h36;

  localparam int VCODE_W = 6;
  localparam int ILIM_W = 2;

  localparam int CTRL_RUN_EN = 0;
  localparam int CTRL_STBY_EN = 1;
  localparam int CTRL_SLEEP_EN = 2;
  localparam int CTRL_LOW_POWER = 3;
  localparam int CTRL_SLEW = 4;
  localparam int CTRL_FORCED_PULSE_WIDTH_FALL = 5;
  localparam int CTRL_FORCED_PULSE_WIDTH = 6;
  localparam int CTRL_DISCH_N = 7;

  localparam int LIM_ILIM_LSB = 0;
  localparam int LIM_TMODE = 4;

  localparam logic [7:0] VOLT_MASK = 8'h3f;
  localparam logic [7:0] CTRL_MASK = 8'hff;
  localparam logic [7:0] LIM_MASK = 8'h13;

  localparam logic [5:0] RST_VCODE = 6'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [1:0] RST_ILIM = 2'h0;
  localparam logic RST_TMODE = 1'b0;

  // System power state, Gray along run, standby, sleep
  typedef enum logic [1:0] {
    PST_RUN = 2'b00,
    PST_STANDBY = 2'b01,
    PST_SLEEP = 2'b11
  } bkreg_pstate_t;

  // Fuse loader states
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_APPLY = 2'b01,
    LD_DONE = 2'b11
  } bkreg_ld_state_t;
endpackage

// File: tb_top.sv
// Self-checking bench for the buck regulator register bank.
// Assumes a free-running 10 MHz clock; all inputs change on the falling edge.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst_n, wr_en, rd_en, rd_valid, v;
  logic [7:0] addr, wdata, rdata, d, a, ctrl_m, lim_m, stby_m, slp_m;
  logic fuse_load, f_run_en, f_slew, f_disch_n, f_scal_sel, sleep_set;
  logic [5:0] f_stby, f_slp, run_code, tgt;
  logic [1:0] f_ilim, pstate, ilim;
  logic en, lp, slow, fpf, fp, disch, tsel;
  logic [31:0] r;
  int n_errors, comparisons, seed;

  bkreg_bank dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rd_valid), .i_fuse_load(fuse_load),
    .i_fuse_standby_vcode(f_stby), .i_fuse_sleep_vcode(f_slp), .i_fuse_run_enable(f_run_en),
    .i_fuse_slew_select(f_slew), .i_fuse_discharge_disable_n(f_disch_n), .i_fuse_current_limit(f_ilim),
    .i_fuse_buck1_scaling_select(f_scal_sel), .i_sleep_enable_set(sleep_set), .i_power_state(pstate),
    .i_buck1_run_voltage_code(run_code), .o_target_voltage_code(tgt), .o_regulator_enable(en),
    .o_low_power(lp), .o_scaling_slow(slow), .o_forced_pwm_on_falling(fpf), .o_forced_pwm(fp),
    .o_discharge_connect(disch), .o_current_limit(ilim), .o_timing_method_select(tsel));

  bkreg_host_model host (.i_clk(i_clk), .i_rdata(rdata), .i_rd_valid(rd_valid), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  function automatic logic [7:0] mdl(input logic [7:0] x);
    case (x)
      8'h33: mdl = stby_m;
      8'h34: mdl = slp_m;
      8'h35: mdl = ctrl_m;
      8'h36: mdl = lim_m;
      default: mdl = 8'h00;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] x, input string nm);
    host.read(x, d, v);
    chk("rd_valid", 8'h01, {7'h0, v});
    chk(nm, mdl(x), d);
  endtask

  task automatic chk_outs();
    logic e;
    logic [5:0] t;
    #10;
    e = (pstate == 2'b01) ? ctrl_m[1] : (pstate == 2'b11) ? ctrl_m[2] : ctrl_m[0];
    t = (pstate == 2'b01) ? stby_m[5:0] : (pstate == 2'b11) ? slp_m[5:0] : run_code;
    chk("target", {2'h0, t}, {2'h0, tgt});
    chk("enable", {7'h0, e}, {7'h0, en});
    chk("low_power", {7'h0, ctrl_m[3] & pstate[0]}, {7'h0, lp});
    chk("slew", {7'h0, ctrl_m[4] & ~f_scal_sel}, {7'h0, slow});
    chk("pwm_fall", {7'h0, ctrl_m[5]}, {7'h0, fpf});
    chk("pwm", {7'h0, ctrl_m[6]}, {7'h0, fp});
    chk("discharge", {7'h0, ~ctrl_m[7] & ~e}, {7'h0, disch});
    chk("ilim", {6'h0, lim_m[1:0]}, {6'h0, ilim});
    chk("timing", {7'h0, lim_m[4]}, {7'h0, tsel});
  endtask

  task automatic give_verdict();
    $display("Counts: %0d comparisons, %0d errors", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    seed = 76;
    n_errors = 0;
    comparisons = 0;
    i_rst_n = 1'b0;
    {fuse_load, f_run_en, f_slew, f_disch_n, f_scal_sel, sleep_set} = 6'h00;
    {f_stby, f_slp, run_code, f_ilim, pstate} = 22'h0;
    {ctrl_m, lim_m, stby_m, slp_m} = 32'h0;
    repeat (12) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk_outs();
    rd_chk(8'h35, "control");
    rd_chk(8'h36, "limit");
    // Fuse loads with random values; codes follow the run code as advised
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      run_code = r[10:5];
      f_stby = run_code;
      f_slp = run_code;
      {f_run_en, f_slew, f_disch_n, f_ilim} = r[4:0];
      fuse_load = 1'b1;
      @(negedge i_clk);
      fuse_load = 1'b0;
      repeat (3) @(negedge i_clk);
      stby_m = {2'h0, run_code};
      slp_m = {2'h0, run_code};
      ctrl_m = {f_disch_n, 2'b00, f_slew, 2'b00, f_run_en, f_run_en};
      lim_m = {6'h0, f_ilim};
      rd_chk(8'h33, "standby");
      rd_chk(8'h34, "sleep");
      rd_chk(8'h35, "control");
      rd_chk(8'h36, "limit");
    end
    // All-ones first, then random bytes, power states and scaling select
    for (int k = 0; k < 60; k++) begin
      r = $random(seed);
      a = 8'h33 + {6'h0, (k < 4) ? k[1:0] : r[1:0]};
      d = (k < 4) ? 8'hff : r[15:8];
      host.write(a, d);
      case (a)
        8'h33: stby_m = d & bkreg_pkg::VOLT_MASK;
        8'h34: slp_m = d & bkreg_pkg::VOLT_MASK;
        8'h35: ctrl_m = d;
        default: lim_m = d & bkreg_pkg::LIM_MASK;
      endcase
      pstate = r[17:16];
      f_scal_sel = r[18];
      run_code = r[24:19];
      chk_outs();
      rd_chk(a, "readback");
    end
    host.write(8'h37, 8'hff);
    rd_chk(8'h37, "unmapped");
    rd_chk(8'h33, "standby");
    host.write(8'h35, ctrl_m & 8'hfb);
    ctrl_m[2] = 1'b0;
    sleep_set = 1'b1;
    repeat (4) @(negedge i_clk);
    ctrl_m[2] = 1'b1;
    rd_chk(8'h35, "sleep_set");
    sleep_set = 1'b0;
    // Let the synchroniser drain, else the set still beats the clear
    repeat (2) @(negedge i_clk);
    host.write(8'h35, ctrl_m & 8'hfb);
    ctrl_m[2] = 1'b0;
    pstate = 2'b11;
    chk_outs();
    rd_chk(8'h35, "sleep_clear");
    // Second reset in mid-run
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    {ctrl_m, lim_m, stby_m, slp_m} = 32'h0;
    rd_chk(8'h35, "control");
    chk_outs();
    give_verdict();
  end
endmodule
